// file: power_state_and_charge_phase_fsm_bench.sv
`timescale 1ns/1ps
`include "psc_defines.svh"
module power_state_and_charge_phase_fsm_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  psc_pkg::psc_pins_s pn;
  psc_pkg::psc_pins_s pins;
  logic [1:0] bcode = 2'h0;
  logic [1:0] gc = 2'h0;
  logic go = 1'b0;
  logic s_ok, l_ok, h_ok;
  logic [1:0] gp;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  psc_pkg::psc_state_e st;
  psc_pkg::psc_phase_e ph;
  psc_pkg::psc_lim_e lim;
  logic chg_on, lin, rp, bc;
  psc_pkg::psc_chg_s sp;
  logic seen_wo = 1'b0, seen_bk = 1'b0, seen_rp = 1'b0;
  logic [31:0] sd = 32'h0000_0049;
  integer n_mismatch = 0;
  integer num_checks = 0;
  integer k;
  always #4 clk = ~clk;
  always_comb
  begin
    pins = pn;
    pins.batt_short_ok = s_ok;
    pins.batt_low_ok = l_ok;
    pins.batt_start_ok = h_ok;
    pins.group_request_pins = gp;
  end
  always @(negedge clk)
  begin
    if (st === psc_pkg::ST_WAIT_ON) seen_wo <= 1'b1;
    if (st === psc_pkg::ST_BACKUP) seen_bk <= 1'b1;
    if (rp === 1'b1) seen_rp <= 1'b1;
  end
  psc_top #(.DEB_CYCLES(4), .SEC_CYCLES(20)) u_dut (.clk(clk), .rst_n(rst_n), .pins(pins),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .power_state(st), .charge_phase(ph), .input_limit(lim), .charge_on(chg_on),
    .linear_mode(lin), .reinit_pulse(rp), .backup_cond(bc), .charge_setpoints(sp));
  psc_far_model u_far (.clk(clk), .batt_code(bcode), .grp_cmd(gc), .grp_go(go),
    .short_ok(s_ok), .low_ok(l_ok), .start_ok(h_ok), .grp_pins(gp));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    integer j;
    for (j = 0; j < 20; j++)
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wst(input psc_pkg::psc_state_e e);
    integer i;
    for (i = 0; i < 300 && st !== e; i++)
      @(negedge clk);
    chk("state", 32'(e), 32'(st));
    if (st !== e) summarize();
  endtask
  task wph(input psc_pkg::psc_phase_e e);
    integer i;
    for (i = 0; i < 300 && ph !== e; i++)
      @(negedge clk);
    chk("phase", 32'(e), 32'(ph));
    if (ph !== e) summarize();
  endtask
  task stay(input psc_pkg::psc_state_e e);
    repeat (8) @(negedge clk);
    chk("state", 32'(e), 32'(st));
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    integer i;
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge clk);
      ta = awv && awready;
      tw = wv && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    if (i == 50)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    integer i;
    logic ta, tv;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge clk);
      ta = arv && arready;
      tv = rvalid === 1'b1;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (!ta && tv) break;
    end
    rready <= 1'b0;
    if (i == 50)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  task press(input integer n);
    @(posedge clk);
    pn.power_button_n <= 1'b0;
    repeat (n) @(posedge clk);
    pn.power_button_n <= 1'b1;
  endtask
  task grp(input logic [1:0] c);
    @(posedge clk);
    gc <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  initial
  begin
    pn = '0;
    pn.power_button_n = 1'b1;
    pn.accessory_n = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wst(psc_pkg::ST_NO_SUPPLY);
    chk("limit", 32'(psc_pkg::LIM_92MA), 32'(lim));
    rd(`PSC_OFS_CTRL, d, r);
    chk("ctrl", 32'h0000_0004, d);
    rd(`PSC_OFS_WDT, d, r);
    chk("wdt", 32'h0000_2020, d);
    rd(8'h10, d, r);
    chk("rresp", 32'(`PSC_RESP_ERR), 32'(r));
    wr(8'h14, 32'h0000_0001, r);
    chk("bresp", 32'(`PSC_RESP_ERR), 32'(r));
    for (k = 0; k < 3; k++)
    begin
      sd = lfsr(sd);
      wr(`PSC_OFS_CHG, sd, r);
      repeat (4) @(negedge clk);
      chk("setpoints", {12'h000, sd[19:0]}, 32'(sp));
      rd(`PSC_OFS_CHG, d, r);
      chk("chg", {12'h000, sd[19:0]}, d);
    end
    @(posedge clk);
    pn.upr_ok <= 1'b1;
    bcode <= 2'h1;
    repeat (6) @(negedge clk);
    chk("backup", 32'h1, 32'(bc));
    @(posedge clk);
    pn.shunt_ok <= 1'b1;
    repeat (6) @(negedge clk);
    chk("backup", 32'h0, 32'(bc));
    bcode <= 2'h2;
    wst(psc_pkg::ST_WAIT_ON);
    press(10);
    stay(psc_pkg::ST_WAIT_ON);
    bcode <= 2'h3;
    press(2);
    stay(psc_pkg::ST_WAIT_ON);
    press(10);
    wst(psc_pkg::ST_ACTIVE);
    pn.warm_reset <= 1'b1;
    stay(psc_pkg::ST_ACTIVE);
    chk("reinit", 32'h1, 32'(seen_rp));
    pn.warm_reset <= 1'b0;
    grp(`PSC_GRP_SLEEP);
    stay(psc_pkg::ST_ACTIVE);
    pn.others_sleep_or_off <= 1'b1;
    grp(`PSC_GRP_SLEEP);
    wst(psc_pkg::ST_SLEEP);
    grp(`PSC_GRP_ACTIVE);
    wst(psc_pkg::ST_ACTIVE);
    grp(`PSC_GRP_SLEEP);
    wst(psc_pkg::ST_SLEEP);
    stay(psc_pkg::ST_SLEEP);
    pn.warm_reset <= 1'b1;
    wst(psc_pkg::ST_ACTIVE);
    pn.warm_reset <= 1'b0;
    seen_wo = 1'b0;
    wr(`PSC_OFS_CTRL, 32'h0000_0005, r);
    repeat (6) @(negedge clk);
    wst(psc_pkg::ST_ACTIVE);
    chk("switch off seen", 32'h1, 32'(seen_wo));
    wr(`PSC_OFS_CTRL, 32'h0000_0006, r);
    stay(psc_pkg::ST_ACTIVE);
    pn.others_off <= 1'b1;
    wr(`PSC_OFS_CTRL, 32'h0000_0006, r);
    wst(psc_pkg::ST_WAIT_ON);
    press(10);
    wst(psc_pkg::ST_ACTIVE);
    pn.thermal_shutdown <= 1'b1;
    wst(psc_pkg::ST_WAIT_ON);
    press(10);
    stay(psc_pkg::ST_WAIT_ON);
    pn.thermal_shutdown <= 1'b0;
    press(10);
    wst(psc_pkg::ST_ACTIVE);
    // ten seconds are 200 cycles at the shortened tick
    pn.power_button_n <= 1'b0;
    repeat (150) @(negedge clk);
    chk("state", 32'(psc_pkg::ST_ACTIVE), 32'(st));
    wst(psc_pkg::ST_WAIT_ON);
    pn.power_button_n <= 1'b1;
    stay(psc_pkg::ST_WAIT_ON);
    press(10);
    wst(psc_pkg::ST_ACTIVE);
    // kick with a two-second period: expiry lands 21 to 40 cycles later
    wr(`PSC_OFS_WDT, 32'h0001_2002, r);
    stay(psc_pkg::ST_ACTIVE);
    wst(psc_pkg::ST_WAIT_ON);
    rd(`PSC_OFS_WDT, d, r);
    chk("wdt period", 32'h0000_0020, {25'h000_0000, d[6:0]});
    pn.usb_id <= 1'b1;
    stay(psc_pkg::ST_WAIT_ON);
    pn.rtc_alarm <= 1'b1;
    wst(psc_pkg::ST_ACTIVE);
    pn.rtc_alarm <= 1'b0;
    bcode <= 2'h1;
    wst(psc_pkg::ST_BACKUP);
    bcode <= 2'h2;
    wst(psc_pkg::ST_WAIT_ON);
    seen_bk = 1'b0;
    pn.upr_ok <= 1'b0;
    bcode <= 2'h1;
    wst(psc_pkg::ST_NO_SUPPLY);
    chk("backup seen", 32'h0, 32'(seen_bk));
    pn.upr_ok <= 1'b1;
    bcode <= 2'h0;
    pn.charger_detect <= 1'b1;
    wph(psc_pkg::PH_PRECOND);
    repeat (4) @(negedge clk);
    chk("limit", 32'(psc_pkg::LIM_30MA), 32'(lim));
    chk("linear", 32'h1, 32'(lin));
    bcode <= 2'h1;
    wph(psc_pkg::PH_PRECHG);
    repeat (4) @(negedge clk);
    chk("limit", 32'(psc_pkg::LIM_92MA), 32'(lim));
    pn.charging_port <= 1'b1;
    repeat (6) @(negedge clk);
    chk("limit", 32'(psc_pkg::LIM_470MA), 32'(lim));
    bcode <= 2'h3;
    wr(`PSC_OFS_CTRL, 32'h0000_0034, r);
    wph(psc_pkg::PH_FULL);
    repeat (4) @(negedge clk);
    chk("limit", 32'(psc_pkg::LIM_SW), 32'(lim));
    chk("charge on", 32'h1, 32'(chg_on));
    bcode <= 2'h1;
    repeat (8) @(negedge clk);
    chk("full left", 32'h0, 32'(ph == psc_pkg::PH_FULL));
    bcode <= 2'h3;
    wph(psc_pkg::PH_FULL);
    wr(`PSC_OFS_WDT, 32'h0000_0120, r);
    wph(psc_pkg::PH_PRECHG);
    repeat (8) @(negedge clk);
    chk("full held off", 32'h0, 32'(ph == psc_pkg::PH_FULL));
    rd(`PSC_OFS_STAT, d, r);
    chk("wdt expired", 32'h1, 32'(d[8]));
    wr(`PSC_OFS_WDT, 32'h0002_2020, r);
    wph(psc_pkg::PH_FULL);
    pn.cv_mode <= 1'b1;
    pn.below_term <= 1'b1;
    wph(psc_pkg::PH_DONE);
    repeat (4) @(negedge clk);
    chk("charge on", 32'h0, 32'(chg_on));
    summarize();
  end
endmodule

// file: psc_defines.svh
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
// register byte offsets
`define PSC_OFS_CTRL 8'h00
`define PSC_OFS_CHG 8'h04
`define PSC_OFS_WDT 8'h08
`define PSC_OFS_STAT 8'h0C
// reset values
`define PSC_CTRL_RST 6'h04
`define PSC_CHG_RST 20'h0_0000
`define PSC_WDT_DEF 7'h20
// timing
`define PSC_CLK_HZ 125000000
`define PSC_DEB_MS 15
`define PSC_LONG_S 4'hA
// group request pin codes
`define PSC_GRP_SLEEP 2'h1
`define PSC_GRP_ACTIVE 2'h2
// bus responses
`define PSC_RESP_OK 2'h0
`define PSC_RESP_ERR 2'h2
`endif

// file: psc_far_model.sv
`timescale 1ns/1ps
module psc_far_model (
  input wire logic clk,
  input wire logic [1:0] batt_code,
  input wire logic [1:0] grp_cmd,
  input wire logic grp_go,
  output logic short_ok,
  output logic low_ok,
  output logic start_ok,
  output logic [1:0] grp_pins = 2'h0
);
  logic [2:0] hold = 3'h0;
  // code 0 shorted, 1 below low, 2 between low and start, 3 above start
  assign short_ok = batt_code != 2'h0;
  assign low_ok = batt_code[1];
  assign start_ok = batt_code == 2'h3;
  // host holds a group command a few cycles, then idles the pins
  always @(posedge clk)
  begin
    if (grp_go)
    begin
      grp_pins <= grp_cmd;
      hold <= 3'h6;
    end
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
    else
      grp_pins <= 2'h0;
  end
endmodule

// file: psc_pkg.sv
package psc_pkg;
  typedef enum logic [2:0] {
    ST_NO_SUPPLY = 3'b000,
    ST_BACKUP = 3'b001,
    ST_WAIT_ON = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_SLEEP = 3'b100
  } psc_state_e;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_PRECOND = 3'b001,
    PH_PRECHG = 3'b010,
    PH_FULL = 3'b011,
    PH_DONE = 3'b100
  } psc_phase_e;
  typedef enum logic [1:0] {
    LIM_30MA = 2'b00,
    LIM_92MA = 2'b01,
    LIM_470MA = 2'b10,
    LIM_SW = 2'b11
  } psc_lim_e;
  typedef struct packed {
    logic full_en;
    logic term_en;
    logic usb_id_en;
    logic bat_en;
    logic device_off_command;
    logic sw_reset;
  } psc_ctrl_s;
  typedef struct packed {
    logic [2:0] input_collapse_voltage;
    logic [3:0] input_current_limit;
    logic [2:0] termination_current_setpoint;
    logic [5:0] charge_voltage_setpoint;
    logic [3:0] charge_current_setpoint;
  } psc_chg_s;
  typedef struct packed {
    logic kick_chg;
    logic kick_pri;
    logic pad1;
    logic [6:0] chg_period;
    logic pad0;
    logic [6:0] pri_period;
  } psc_wdt_s;
  typedef struct packed {
    logic upr_ok;
    logic batt_low_ok;
    logic batt_start_ok;
    logic shunt_ok;
    logic batt_short_ok;
    logic power_button_n;
    logic accessory_n;
    logic charger_detect;
    logic charging_port;
    logic rtc_alarm;
    logic usb_id;
    logic battery_insert;
    logic thermal_shutdown;
    logic warm_reset;
    logic [1:0] group_request_pins;
    logic others_sleep_or_off;
    logic others_off;
    logic cv_mode;
    logic below_term;
  } psc_pins_s;
endpackage

// file: psc_top.sv
// Notes on behaviour
// - backup condition is battery below low threshold and shunt below minimum.
// - uninterrupted supply below POR threshold means no-supply state.
// - from no-supply or backup, battery above low threshold enters wait-on.
// - loss of uninterrupted supply forces no-supply from any state.
// - wait-on goes active on any trigger if start threshold met, no thermal.
// - battery trigger enabled and USB ID trigger disabled after reset.
// - active or sleep go wait-on on device-off with others off, thermal, watchdog, reset, long press.
// - software reset switches off, then automatically switches back on.
// - group sleep command enters sleep only when other groups sleep or off.
// - sleep returns active on group active command or warm reset.
// - warm reset in active reinitialises and stays active.
// - low battery with supply present enters backup from active, sleep, wait-on.
// - charger detection starts preconditioning, linear charging at 30 mA.
// - battery above short threshold moves preconditioning to precharge.
// - precharge limits input to 92 mA, or 470 mA on charging port.
// - full charge only above start threshold, stopped below low threshold.
// - software setpoints for current, voltage, termination, input limit, collapse.
// - charge watchdog period up to 127 s, default 32 s.
// - enabled termination in constant voltage stops charge at end of charge.
// - button press confirmed after 15 ms, then acts per state.
// - primary watchdog 1 to 127 s, default 32, starts leaving wait-on.
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_top #(
  parameter int unsigned DEB_CYCLES = `PSC_CLK_HZ / 1000 * `PSC_DEB_MS,
  parameter int unsigned SEC_CYCLES = `PSC_CLK_HZ
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire psc_pkg::psc_pins_s pins,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output psc_pkg::psc_state_e power_state,
  output psc_pkg::psc_phase_e charge_phase,
  output psc_pkg::psc_lim_e input_limit,
  output logic charge_on,
  output logic linear_mode,
  output logic reinit_pulse,
  output logic backup_cond,
  output psc_pkg::psc_chg_s charge_setpoints
);
  localparam int CW = $bits(psc_pkg::psc_ctrl_s);
  localparam int GW = $bits(psc_pkg::psc_chg_s);
  localparam int WW = $bits(psc_pkg::psc_wdt_s);

  function automatic logic [31:0] psc_merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0] s
  );
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++)
    begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return (old & ~m) | (d & m);
  endfunction

  // pins pass two flops before use
  psc_pkg::psc_pins_s meta_reg, p, prev_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      p <= '0;
      prev_reg <= '0;
      // buttons idle high; resetting them low would fake a press
      meta_reg.power_button_n <= 1'b1;
      meta_reg.accessory_n <= 1'b1;
      p.power_button_n <= 1'b1;
      p.accessory_n <= 1'b1;
    end
    else
    begin
      meta_reg <= pins;
      p <= meta_reg;
      prev_reg <= p;
    end
  end

  wire logic pwr_fail = !p.upr_ok;
  wire logic low_bat = !p.batt_low_ok;
  wire logic chg_plug = p.charger_detect && !prev_reg.charger_detect;
  wire logic ins_rise = p.battery_insert && !prev_reg.battery_insert;
  wire logic id_rise = p.usb_id && !prev_reg.usb_id;
  wire logic warm_rise = p.warm_reset && !prev_reg.warm_reset;
  wire logic [1:0] raw_press = {!p.accessory_n, !p.power_button_n};

  // debounce for button (0) and accessory (1)
  logic [1:0] conf;
  logic [1:0] conf_prev_reg;
  genvar gi;
  for (gi = 0; gi < 2; gi++)
  begin : g_deb
    logic [31:0] cnt_reg;
    logic conf_q;
    always_ff @(posedge clk)
    begin
      if (!rst_n || !raw_press[gi])
      begin
        cnt_reg <= 32'h0000_0000;
        conf_q <= 1'b0;
      end
      else if (cnt_reg < DEB_CYCLES - 1)
        cnt_reg <= cnt_reg + 32'h0000_0001;
      else
        conf_q <= 1'b1;
    end
    assign conf[gi] = conf_q;
  end
  always_ff @(posedge clk)
  begin
    conf_prev_reg <= rst_n ? conf : 2'b00;
  end
  wire logic acc_press = conf[1] && !conf_prev_reg[1];

  // one-second tick shared by long press and both watchdogs
  logic [31:0] sec_cnt_reg;
  logic tick_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n || sec_cnt_reg >= SEC_CYCLES - 1)
      sec_cnt_reg <= 32'h0000_0000;
    else
      sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
    tick_reg <= rst_n && (sec_cnt_reg >= SEC_CYCLES - 1);
  end

  // long press counts whole seconds of a confirmed press
  logic [3:0] long_cnt_reg;
  wire logic long_hit = long_cnt_reg >= `PSC_LONG_S;
  always_ff @(posedge clk)
  begin
    if (!rst_n || !conf[0])
      long_cnt_reg <= 4'h0;
    else if (tick_reg && !long_hit)
      long_cnt_reg <= long_cnt_reg + 4'h1;
  end
  // a release that ends a long press must not switch straight back on
  wire logic btn_release = conf_prev_reg[0] && !conf[0] && !long_hit;

  // register file
  psc_pkg::psc_ctrl_s ctrl_reg;
  psc_pkg::psc_wdt_s wdt_reg;
  psc_pkg::psc_state_e state_reg, state_next;
  psc_pkg::psc_phase_e phase_reg, phase_next;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_full_reg, w_full_reg, chg_exp_reg, restart_reg;
  wire logic aw_hs = s_axi_awvalid && s_axi_awready;
  wire logic w_hs = s_axi_wvalid && s_axi_wready;
  wire logic ar_hs = s_axi_arvalid && s_axi_arready;
  wire logic do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire logic wr_ctrl = do_wr && awaddr_reg == `PSC_OFS_CTRL;
  wire logic wr_chg = do_wr && awaddr_reg == `PSC_OFS_CHG;
  wire logic wr_wdt = do_wr && awaddr_reg == `PSC_OFS_WDT;
  wire logic wr_hit = wr_ctrl || wr_chg || wr_wdt || awaddr_reg == `PSC_OFS_STAT;
  wire logic [31:0] m_ctrl = psc_merge(32'(ctrl_reg), wdata_reg, wstrb_reg);
  wire logic [31:0] m_chg = psc_merge(32'(charge_setpoints), wdata_reg, wstrb_reg);
  wire logic [31:0] m_wdt = psc_merge(32'(wdt_reg), wdata_reg, wstrb_reg);
  wire logic aw_full_next = (aw_full_reg || aw_hs) && !do_wr;
  wire logic w_full_next = (w_full_reg || w_hs) && !do_wr;
  wire logic rvalid_next = (s_axi_rvalid && !s_axi_rready) || ar_hs;
  wire logic [31:0] stat_word = {23'h00_0000, chg_exp_reg, phase_reg == psc_pkg::PH_DONE,
    backup_cond, phase_reg, state_reg};
  wire logic [31:0] rd_word =
    s_axi_araddr == `PSC_OFS_CTRL ? 32'(ctrl_reg) :
    s_axi_araddr == `PSC_OFS_CHG ? 32'(charge_setpoints) :
    s_axi_araddr == `PSC_OFS_WDT ? 32'(wdt_reg) : stat_word;
  wire logic rd_hit = s_axi_araddr == `PSC_OFS_CTRL || s_axi_araddr == `PSC_OFS_CHG ||
    s_axi_araddr == `PSC_OFS_WDT || s_axi_araddr == `PSC_OFS_STAT;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSC_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PSC_RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      s_axi_awready <= !aw_full_next;
      s_axi_wready <= !w_full_next;
      if (aw_hs)
        awaddr_reg <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_wr)
        s_axi_bresp <= wr_hit ? `PSC_RESP_OK : `PSC_RESP_ERR;
      s_axi_bvalid <= do_wr || (s_axi_bvalid && !s_axi_bready);
      s_axi_rvalid <= rvalid_next;
      s_axi_arready <= !rvalid_next;
      if (ar_hs)
      begin
        s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
        s_axi_rresp <= rd_hit ? `PSC_RESP_OK : `PSC_RESP_ERR;
      end
    end
  end

  // sw_reset, device-off and kick bits are one-cycle pulses
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `PSC_CTRL_RST;
      charge_setpoints <= `PSC_CHG_RST;
      wdt_reg <= {3'b000, `PSC_WDT_DEF, 1'b0, `PSC_WDT_DEF};
    end
    else
    begin
      ctrl_reg <= wr_ctrl ? psc_pkg::psc_ctrl_s'(m_ctrl[CW-1:0]) :
        {ctrl_reg[CW-1:2], 2'b00};
      if (wr_chg)
        charge_setpoints <= psc_pkg::psc_chg_s'(m_chg[GW-1:0]);
      if (wr_wdt)
        wdt_reg <= psc_pkg::psc_wdt_s'(m_wdt[WW-1:0]);
      else
        wdt_reg <= {2'b00, wdt_reg[WW-3:0]};
      if (state_reg == psc_pkg::ST_WAIT_ON && !wr_wdt)
        wdt_reg.pri_period <= `PSC_WDT_DEF;
    end
  end

  // watchdogs count seconds; a zero period acts as one second
  logic [6:0] pri_cnt_reg, chg_cnt_reg;
  wire logic [6:0] pri_per = wdt_reg.pri_period == 7'h00 ? 7'h01 : wdt_reg.pri_period;
  wire logic [6:0] chg_per = wdt_reg.chg_period == 7'h00 ? 7'h01 : wdt_reg.chg_period;
  wire logic running = state_reg == psc_pkg::ST_ACTIVE || state_reg == psc_pkg::ST_SLEEP;
  wire logic pri_exp = running && pri_cnt_reg >= pri_per;
  wire logic chg_exp = phase_reg == psc_pkg::PH_FULL && chg_cnt_reg >= chg_per;
  always_ff @(posedge clk)
  begin
    if (!rst_n || !running || wdt_reg.kick_pri)
      pri_cnt_reg <= 7'h00;
    else if (tick_reg && !pri_exp)
      pri_cnt_reg <= pri_cnt_reg + 7'h01;
    if (!rst_n || phase_reg != psc_pkg::PH_FULL || wdt_reg.kick_chg)
      chg_cnt_reg <= 7'h00;
    else if (tick_reg && !chg_exp)
      chg_cnt_reg <= chg_cnt_reg + 7'h01;
    if (!rst_n)
      chg_exp_reg <= 1'b0;
    else if (chg_exp)
      chg_exp_reg <= 1'b1;
    else if (wdt_reg.kick_chg)
      chg_exp_reg <= 1'b0;
  end

  // power state machine
  wire logic off_trig = (ctrl_reg.device_off_command && p.others_off) ||
    p.thermal_shutdown || pri_exp || ctrl_reg.sw_reset || long_hit;
  wire logic on_trig = btn_release || acc_press || chg_plug || p.rtc_alarm ||
    (ctrl_reg.bat_en && (ins_rise || phase_reg != psc_pkg::PH_IDLE)) ||
    (ctrl_reg.usb_id_en && id_rise) || restart_reg;
  wire logic on_ok = p.batt_start_ok && !p.thermal_shutdown;
  wire logic go_sleep = p.group_request_pins == `PSC_GRP_SLEEP && p.others_sleep_or_off;
  wire logic go_wake = p.group_request_pins == `PSC_GRP_ACTIVE || warm_rise;

  always_comb
  begin
    state_next = state_reg;
    if (pwr_fail)
      state_next = psc_pkg::ST_NO_SUPPLY;
    else
    begin
      case (state_reg)
        psc_pkg::ST_NO_SUPPLY:
          state_next = low_bat ? psc_pkg::ST_BACKUP : psc_pkg::ST_WAIT_ON;
        psc_pkg::ST_BACKUP:
          if (!low_bat)
            state_next = psc_pkg::ST_WAIT_ON;
        psc_pkg::ST_WAIT_ON:
          if (low_bat)
            state_next = psc_pkg::ST_BACKUP;
          else if (on_trig && on_ok)
            state_next = psc_pkg::ST_ACTIVE;
        psc_pkg::ST_ACTIVE:
          if (low_bat)
            state_next = psc_pkg::ST_BACKUP;
          else if (off_trig)
            state_next = psc_pkg::ST_WAIT_ON;
          else if (go_sleep)
            state_next = psc_pkg::ST_SLEEP;
        psc_pkg::ST_SLEEP:
          if (low_bat)
            state_next = psc_pkg::ST_BACKUP;
          else if (off_trig)
            state_next = psc_pkg::ST_WAIT_ON;
          else if (go_wake)
            state_next = psc_pkg::ST_ACTIVE;
        default:
          state_next = psc_pkg::ST_NO_SUPPLY;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= psc_pkg::ST_NO_SUPPLY;
      restart_reg <= 1'b0;
      reinit_pulse <= 1'b0;
      backup_cond <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      // restart survives the off transition and fires the next switch-on
      if (running && ctrl_reg.sw_reset && state_next == psc_pkg::ST_WAIT_ON)
        restart_reg <= 1'b1;
      else if (state_next != psc_pkg::ST_WAIT_ON)
        restart_reg <= 1'b0;
      reinit_pulse <= warm_rise && running && state_next == psc_pkg::ST_ACTIVE;
      backup_cond <= low_bat && !p.shunt_ok;
    end
  end
  assign power_state = state_reg;

  // charge phase machine
  always_comb
  begin
    phase_next = phase_reg;
    if (!p.charger_detect)
      phase_next = psc_pkg::PH_IDLE;
    else
    begin
      case (phase_reg)
        psc_pkg::PH_IDLE:
          phase_next = psc_pkg::PH_PRECOND;
        psc_pkg::PH_PRECOND:
          if (p.batt_short_ok)
            phase_next = psc_pkg::PH_PRECHG;
        psc_pkg::PH_PRECHG:
          if (!p.batt_short_ok)
            phase_next = psc_pkg::PH_PRECOND;
          else if (ctrl_reg.full_en && p.batt_start_ok && !chg_exp_reg)
            phase_next = psc_pkg::PH_FULL;
        psc_pkg::PH_FULL:
          if (low_bat || chg_exp)
            phase_next = psc_pkg::PH_PRECHG;
          else if (ctrl_reg.term_en && p.cv_mode && p.below_term)
            phase_next = psc_pkg::PH_DONE;
        psc_pkg::PH_DONE:
          if (!ctrl_reg.full_en)
            phase_next = psc_pkg::PH_PRECHG;
        default:
          phase_next = psc_pkg::PH_IDLE;
      endcase
    end
  end

  wire psc_pkg::psc_lim_e lim_next =
    phase_next == psc_pkg::PH_PRECOND ? psc_pkg::LIM_30MA :
    phase_next == psc_pkg::PH_FULL ? psc_pkg::LIM_SW :
    p.charging_port ? psc_pkg::LIM_470MA : psc_pkg::LIM_92MA;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase_reg <= psc_pkg::PH_IDLE;
      input_limit <= psc_pkg::LIM_92MA;
      charge_on <= 1'b0;
      linear_mode <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      input_limit <= lim_next;
      charge_on <= phase_next inside {psc_pkg::PH_PRECOND, psc_pkg::PH_PRECHG,
        psc_pkg::PH_FULL};
      linear_mode <= phase_next == psc_pkg::PH_PRECOND;
    end
  end
  assign charge_phase = phase_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic keep_on = p.upr_ok && p.batt_low_ok && p.batt_start_ok && !p.thermal_shutdown;
  sequence s_swr_hit;
    state_reg == psc_pkg::ST_ACTIVE && ctrl_reg.sw_reset && keep_on ##1 keep_on;
  endsequence
  sequence s_off_on;
    state_reg == psc_pkg::ST_WAIT_ON ##1 state_reg == psc_pkg::ST_ACTIVE;
  endsequence
  a_supply_loss: assert property (pwr_fail |=> state_reg == psc_pkg::ST_NO_SUPPLY)
    else $error("supply loss did not reach no-supply");
  a_backup_entry: assert property (p.upr_ok && low_bat &&
    state_reg inside {psc_pkg::ST_ACTIVE, psc_pkg::ST_SLEEP, psc_pkg::ST_WAIT_ON}
    |=> state_reg == psc_pkg::ST_BACKUP)
    else $error("low battery did not enter backup");
  a_switch_on_gate: assert property (s_off_on |-> $past(on_ok))
    else $error("switch-on without start threshold");
  a_sw_restart: assert property (s_swr_hit |-> s_off_on)
    else $error("software reset did not restart");
  a_thermal_off: assert property (running && p.thermal_shutdown && p.upr_ok && !low_bat
    |=> state_reg == psc_pkg::ST_WAIT_ON)
    else $error("thermal shutdown ignored");
  a_sleep_gate: assert property (state_reg == psc_pkg::ST_ACTIVE ##1
    state_reg == psc_pkg::ST_SLEEP |-> $past(p.others_sleep_or_off))
    else $error("sleep entered while a group active");
  a_precond_limit: assert property (phase_reg == psc_pkg::PH_PRECOND |->
    input_limit == psc_pkg::LIM_30MA && linear_mode && charge_on)
    else $error("preconditioning limit wrong");
  a_full_gate: assert property (phase_reg != psc_pkg::PH_FULL ##1
    phase_reg == psc_pkg::PH_FULL |-> $past(p.batt_start_ok && ctrl_reg.full_en))
    else $error("full charge entered below start threshold");
  a_term_stop: assert property (phase_reg == psc_pkg::PH_FULL && p.charger_detect &&
    !low_bat && !chg_exp && ctrl_reg.term_en && p.cv_mode && p.below_term
    |=> phase_reg == psc_pkg::PH_DONE && !charge_on)
    else $error("termination did not stop charge");
endmodule
